// >>> shared/sbcg_cfg.svh
// Offsets, field positions, reset values and timing counts of the serial clock front end
`ifndef SBCG_CFG_SVH
`define SBCG_CFG_SVH
// Register offsets inside one channel window
`define SBCG_OFF_BAUD_CTRL 5'h00
`define SBCG_OFF_BAUD_FRAC 5'h04
`define SBCG_OFF_SER_MODE 5'h08
`define SBCG_OFF_SER_CTRL 5'h0C
`define SBCG_OFF_STATUS 5'h10
// Channel window select bit inside the APB address
`define SBCG_CH_BIT 5
// baud_control_reg fields
`define SBCG_N_LSB 0
`define SBCG_SRC_LSB 4
`define SBCG_FRAC_EN_BIT 6
// baud_fraction_reg field
`define SBCG_K_LSB 0
// serial_mode_reg fields
`define SBCG_SCS_LSB 0
`define SBCG_MODE_LSB 2
`define SBCG_PAR_BIT 4
`define SBCG_WAKE_BIT 5
// serial_control_reg fields
`define SBCG_DIR_BIT 0
`define SBCG_EDGE_BIT 1
// Reset value of every configuration field
`define SBCG_CFG_RST 22'h000000
// Receive counter figures
`define SBCG_SAMPLE_A 4'h7
`define SBCG_SAMPLE_B 4'h8
`define SBCG_SAMPLE_C 4'h9
// Character lengths of the UART modes
`define SBCG_BITS_M1 4'h7
`define SBCG_BITS_M2 4'h8
`define SBCG_BITS_M3 4'h9
`endif

// >>> shared/sbcg_pkg.sv
// Types of the serial clock front end
package sbcg_pkg;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} sbcg_rx_e;
	typedef struct packed {
		logic [3:0] int_divisor_n;
		logic [1:0] baud_src_select;
		logic frac_div_enable;
		logic [3:0] frac_divisor_k;
		logic [1:0] mode;
		logic [1:0] sample_clock_src;
		logic parity_en;
		logic wake_en;
		logic shift_clock_dir;
		logic shift_edge_select;
		logic [3:0] spare;
	} sbcg_cfg_s;
	typedef struct packed {
		logic [2:0] rx_sync;
		logic rx_lvl;
		logic [2:0] sck_sync;
		logic sck_lvl;
		logic sck_prev;
		logic half;
		logic [3:0] rx_cnt;
		logic [1:0] votes;
		sbcg_rx_e rx_st;
		logic [3:0] bit_idx;
		logic rx_bit;
		logic bit_valid;
	} sbcg_chan_s;
	typedef struct packed {
		logic [1:0] div4;
		logic [5:0] presc;
		sbcg_cfg_s [1:0] cfg;
		sbcg_chan_s [1:0] ch;
		logic [31:0] prdata;
	} sbcg_state_s;
	typedef struct packed {
		logic [4:0] cnt;
		logic [3:0] acc;
		logic long_per;
		logic pulse;
	} sbcg_baud_s;
endpackage : sbcg_pkg

// >>> tb/sbcg_peer.sv
// Serial peer model driving the receive lines and shift clock pins
`timescale 1ns/1ns
module sbcg_peer (
	input wire logic pclk,
	input wire logic tick,
	output logic [1:0] rx,
	output logic [1:0] sclk
);
	int stuck;
	// Line idles high, shift clock stands still between frames
	initial begin
		rx = 2'h3;
		sclk = 2'h0;
		stuck = 0;
	end
	// Paced by the receiver's sample pulses, a peer at a matched rate
	task automatic ticks(input int n);
		int w;
		repeat (n) begin
			w = 0;
			do begin
				@(posedge pclk);
				w++;
			end while (tick !== 1'b1 && w < 64);
			if (w >= 64) stuck++;
		end
	endtask : ticks
	// Start, nb bits LSB first, stop; one sample of bit gb is flipped
	task automatic send(input logic [8:0] d, input int nb, input int gb);
		logic [10:0] f;
		f = 11'h7FF;
		f[0] = 1'b0;
		for (int i = 0; i < nb; i++) f[i + 1] = d[i];
		ticks(1);
		for (int i = 0; i <= nb + 1; i++) begin
			rx[0] <= f[i];
			ticks(8);
			if (i == gb) rx[0] <= ~f[i];
			ticks(1);
			rx[0] <= f[i];
			ticks(7);
		end
	endtask : send
	// Low pulse one sample period wide, too short for a start bit
	task automatic blip;
		ticks(1);
		rx[0] <= 1'b0;
		ticks(1);
		rx[0] <= 1'b1;
		ticks(24);
	endtask : blip
	// One shift clock level, held far below the fc/4 limit
	task automatic step(input logic v);
		sclk[0] <= v;
		repeat (12) @(posedge pclk);
	endtask : step
endmodule : sbcg_peer

// >>> tb/tb_sbcg_top.sv
// Self-checking bench of the serial clock front end
`timescale 1ns/1ns
`include "sbcg_cfg.svh"
module tb_sbcg_top;
	localparam logic [7:0] BC = {3'h0, `SBCG_OFF_BAUD_CTRL};
	localparam logic [7:0] BF = {3'h0, `SBCG_OFF_BAUD_FRAC};
	localparam logic [7:0] MD = {3'h0, `SBCG_OFF_SER_MODE};
	localparam logic [7:0] SC = {3'h0, `SBCG_OFF_SER_CTRL};
	localparam logic [7:0] ST = {3'h0, `SBCG_OFF_STATUS};
	localparam logic [8:0] DAT = 9'h1A5;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic timer0_match = 1'b0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er;
	logic [1:0] rx, sclk, sco, scoe, bsc, rvalid, rval, par, wake;
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;
	int pc = 0;
	int c;
	logic qv[$];
	int qt[$];
	int pctl[5] = '{32'h01, 32'h00, 32'h13, 32'h22, 32'h31};
	int pexp[5] = '{4, 64, 48, 128, 256};
	int rmask[4] = '{32'h7F, 32'h0F, 32'h3F, 32'h03};
	always #25 pclk = ~pclk;
	always @(posedge pclk) cyc <= cyc + 1;
	// Monitors on the falling edge, clear of input updates
	always @(negedge pclk) begin
		if (bsc[0] === 1'b1) pc++;
		if (rvalid[0] === 1'b1) begin
			qv.push_back(rval[0]);
			qt.push_back(cyc);
		end
	end
	sbcg_top u_sbcg_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ser_rx_pin(rx), .shift_clock_in(sclk), .shift_clock_out(sco),
		.shift_clock_oe(scoe), .timer0_match(timer0_match), .basic_sample_clock(bsc),
		.rx_bit_valid(rvalid), .rx_bit_value(rval), .parity_active(par), .wake_active(wake));
	sbcg_peer u_sbcg_peer (.pclk(pclk), .tick(bsc[0]), .rx(rx), .sclk(sclk));
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// A used-up wait bound ends the run
	task automatic tmo;
		chk("wait bound", 0, 1);
		give_verdict();
	endtask : tmo
	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 64) tmo();
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h0);
		chk("read data", e, rd);
		chk("slave error", ee, er);
	endtask : rdc
	// Cycles from the first seen basic pulse to the n-th one after it
	task automatic span(input int ch, input int n);
		int k, t0;
		k = 0;
		t0 = 0;
		for (int i = 0; i < 5000 && k <= n; i++) begin
			@(negedge pclk);
			if (bsc[ch] === 1'b1) begin
				if (k == 0) t0 = i;
				k++;
				c = i - t0;
			end
		end
		if (k <= n) tmo();
	endtask : span
	task automatic frame(input int m, input int p, input int nb);
		qv.delete();
		qt.delete();
		apb(1'b1, MD, 32'(m * 4 + p * 16));
		u_sbcg_peer.send(DAT, nb, m + 1);
		repeat (8) @(posedge pclk);
		chk("decision count", nb + 1, qv.size());
		for (int i = 0; i < qv.size() && i <= nb; i++) begin
			chk("bit value", (i < nb) ? DAT[i] : 1'b1, qv[i]);
			if (i > 0) chk("bit spacing", 128, qt[i] - qt[i - 1]);
		end
	endtask : frame
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values of every register, read-back of the four writable ones of channel 0
		for (int i = 0; i < 5; i++) rdc(8'(i * 4), 0, 1'b0);
		for (int i = 0; i < 5; i++) rdc(8'(i * 4 + 32), 0, 1'b0);
		chk("output enable", 2'h3, scoe);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 8'(i * 4), 32'hFFFFFFFF);
			rdc(8'(i * 4), rmask[i], 1'b0);
			if (i == 0) rdc(8'h40, 0, 1'b1);
			apb(1'b1, 8'(i * 4), 32'h0);
		end
		// Refused accesses leave a slave error
		rdc(8'h14, 0, 1'b1);
		apb(1'b1, ST, 32'h5);
		chk("status write error", 1, er);
		// Parity and wake-up follow the mode
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, MD, 32'(m * 4 + 48));
			// Config lands at the access edge; look once it has settled
			@(negedge pclk);
			chk("parity", m == 1 || m == 2, par[0]);
			chk("wake", m == 3, wake[0]);
		end
		chk("other channel", 2'h0, {par[1], wake[1]});
		// Integer division over every tap and both ends of N
		apb(1'b1, MD, 32'h04);
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, BC, pctl[i]);
			span(0, 1);
			chk("baud period", pexp[i], c);
		end
		apb(1'b1, BC + 8'h20, 32'h03);
		span(1, 1);
		chk("second channel period", 24, c);
		repeat (2) @(negedge pclk);
		chk("shift clock out", 1, sco[1]);
		// Fraction ignored while disabled, applied while enabled at N of 2
		apb(1'b1, BF, 32'h8);
		apb(1'b1, BC, 32'h02);
		span(0, 1);
		chk("fraction off", 8, c);
		for (int k = 1; k < 16; k += 7) begin
			apb(1'b1, BF, 32'(k));
			apb(1'b1, BC, 32'h42);
			span(0, 16);
			chk("fraction span", (48 - k) * 4, c);
		end
		apb(1'b1, MD, 32'h05);
		span(0, 1);
		chk("half clock", 2, c);
		// Timer pulse source in UART mode, then ignored in I/O mode
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, SC, 32'h1);
			apb(1'b1, MD, m ? 32'h02 : 32'h06);
			pc = 0;
			repeat (5) begin
				timer0_match <= 1'b1;
				@(posedge pclk);
				timer0_match <= 1'b0;
				repeat (5) @(posedge pclk);
			end
			chk("timer pulses", m ? 0 : 5, pc);
		end
		// External clock pin as UART source
		apb(1'b1, MD, 32'h07);
		pc = 0;
		repeat (4) begin
			u_sbcg_peer.step(1'b1);
			u_sbcg_peer.step(1'b0);
		end
		chk("pin pulses", 4, pc);
		// I/O input clock, rising then falling edge
		apb(1'b1, MD, 32'h00);
		for (int e = 0; e < 2; e++) begin
			apb(1'b1, SC, 32'(e * 2 + 1));
			chk("output enable off", 0, scoe[0]);
			pc = 0;
			u_sbcg_peer.step(1'b1);
			chk("rise pulses", e == 0, pc);
			pc = 0;
			u_sbcg_peer.step(1'b0);
			chk("fall pulses", e == 1, pc);
		end
		// UART reception at 8 cycles per sample pulse
		apb(1'b1, BC, 32'h02);
		apb(1'b1, MD, 32'h04);
		qv.delete();
		u_sbcg_peer.blip();
		chk("false start", 0, qv.size());
		frame(1, 1, 8);
		frame(2, 0, 8);
		frame(3, 1, 9);
		frame(1, 0, 7);
		chk("peer waits", 0, u_sbcg_peer.stuck);
		give_verdict();
	end
endmodule : tb_sbcg_top

// >>> verilog/sbcg_baud.sv
// Baud rate divider with integer and fractional division
`timescale 1ns/1ns
`include "sbcg_cfg.svh"
module sbcg_baud import sbcg_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tap_en,
	input wire logic restart,
	input wire logic [3:0] n,
	input wire logic [3:0] k,
	input wire logic frac_en,
	output logic pulse
);
	sbcg_baud_s s_q;
	sbcg_baud_s s_d;
	logic [4:0] div;
	logic [4:0] limit;
	logic [4:0] sum;

	// Code zero of the divisor stands for 16
	assign div = (n == 4'h0) ? 5'h10 : {1'b0, n};
	assign limit = div + {4'h0, s_q.long_per};
	assign sum = {1'b0, s_q.acc} + (5'h10 - {1'b0, k});

	// Spread the (16-K)/16 extra taps over periods by an accumulator
	always_comb begin
		s_d = s_q;
		s_d.pulse = 1'b0;
		if (restart) begin
			s_d = '0;
		end else if (tap_en) begin
			if (s_q.cnt + 5'h01 >= limit) begin
				s_d.cnt = 5'h00;
				s_d.pulse = 1'b1;
				s_d.acc = frac_en ? sum[3:0] : 4'h0;
				s_d.long_per = frac_en & sum[4];
			end else begin
				s_d.cnt = s_q.cnt + 5'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pulse = s_q.pulse;

	property p_int_period;
		@(posedge pclk) disable iff (!presetn)
		s_q.pulse && !frac_en |-> s_q.cnt == 5'h00 && !s_q.long_per;
	endproperty
	a_int_period: assert property (p_int_period) else $error("integer period used extra tap");

	property p_frac_long;
		@(posedge pclk) disable iff (!presetn)
		tap_en && !restart && s_q.cnt + 5'h01 >= limit && frac_en |=> s_q.long_per == $past(sum[4]);
	endproperty
	a_frac_long: assert property (p_frac_long) else $error("fraction carry not applied");
endmodule : sbcg_baud

// >>> verilog/sbcg_top.sv
// Serial clock generation and receive sampling front end, two channels, APB registers
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ns
`include "sbcg_cfg.svh"
module sbcg_top import sbcg_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] ser_rx_pin,
	input wire logic [1:0] shift_clock_in,
	output logic [1:0] shift_clock_out,
	output logic [1:0] shift_clock_oe,
	input wire logic timer0_match,
	output logic [1:0] basic_sample_clock,
	output logic [1:0] rx_bit_valid,
	output logic [1:0] rx_bit_value,
	output logic [1:0] parity_active,
	output logic [1:0] wake_active
);
	sbcg_state_s s_q;
	sbcg_state_s s_d;
	logic setup;
	logic wr;
	logic hit;
	logic [4:0] off;
	logic chs;
	logic presc_run;
	logic tick4;
	logic [3:0] taps;
	logic [1:0] baud_pulse;
	logic [1:0] restart;
	logic [1:0] sck_rise;
	logic [1:0] sck_fall;
	logic [1:0] basic;

	// Zero wait slave; read data is caught in the setup cycle
	assign pready = 1'b1;
	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;
	assign off = paddr[4:0];
	assign chs = paddr[`SBCG_CH_BIT];
	assign hit = (paddr[7:6] == 2'b00) && (off <= `SBCG_OFF_STATUS) && (off[1:0] == 2'b00);
	assign pslverr = psel && penable && (!hit || (pwrite && off == `SBCG_OFF_STATUS));

	// Divide by four feeds the shared prescaler
	assign tick4 = (s_q.div4 == 2'h3);
	// Taps fire on the last count of each prescaler stage
	assign taps[0] = tick4 && presc_run;
	assign taps[1] = taps[0] && (s_q.presc[1:0] == 2'h3);
	assign taps[2] = taps[0] && (s_q.presc[3:0] == 4'hF);
	assign taps[3] = taps[0] && (s_q.presc == 6'h3F);

	// Prescaler only runs while a channel uses its baud generator
	always_comb begin
		presc_run = 1'b0;
		for (int i = 0; i < 2; i++) begin
			if (s_q.cfg[i].mode != 2'h0 && s_q.cfg[i].sample_clock_src == 2'h0) begin
				presc_run = 1'b1;
			end
			if (s_q.cfg[i].mode == 2'h0 && !s_q.cfg[i].shift_clock_dir) begin
				presc_run = 1'b1;
			end
		end
	end

	// Per channel divider, clock selection and pin outputs
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			// Rewriting divider or source fields restarts the period
			assign restart[g] = wr && hit && chs == 1'(g) &&
				(off == `SBCG_OFF_BAUD_CTRL || off == `SBCG_OFF_BAUD_FRAC ||
				off == `SBCG_OFF_SER_MODE || off == `SBCG_OFF_SER_CTRL);
			sbcg_baud u_baud (
				.pclk(pclk),
				.presetn(presetn),
				.tap_en(taps[s_q.cfg[g].baud_src_select]),
				.restart(restart[g]),
				.n(s_q.cfg[g].int_divisor_n),
				.k(s_q.cfg[g].frac_divisor_k),
				.frac_en(s_q.cfg[g].frac_div_enable),
				.pulse(baud_pulse[g])
			);
			// Edges are taken from the filtered level, not the raw pin
			assign sck_rise[g] = s_q.ch[g].sck_lvl && !s_q.ch[g].sck_prev;
			assign sck_fall[g] = !s_q.ch[g].sck_lvl && s_q.ch[g].sck_prev;
			// Basic clock source per mode; timer 0 never reaches I/O mode
			always_comb begin
				basic[g] = 1'b0;
				if (s_q.cfg[g].mode == 2'h0) begin
					if (!s_q.cfg[g].shift_clock_dir) begin
						basic[g] = baud_pulse[g] && !s_q.ch[g].half;
					end else if (s_q.cfg[g].shift_edge_select) begin
						basic[g] = sck_fall[g];
					end else begin
						basic[g] = sck_rise[g];
					end
				end else begin
					case (s_q.cfg[g].sample_clock_src)
						2'h0: basic[g] = baud_pulse[g];
						2'h1: basic[g] = s_q.div4[0];
						2'h2: basic[g] = timer0_match;
						2'h3: basic[g] = sck_rise[g];
						default: basic[g] = 1'b0;
					endcase
				end
			end
			assign shift_clock_out[g] = s_q.ch[g].half;
			assign shift_clock_oe[g] = (s_q.cfg[g].mode == 2'h0) && !s_q.cfg[g].shift_clock_dir;
			assign parity_active[g] = s_q.cfg[g].parity_en &&
				(s_q.cfg[g].mode == 2'h1 || s_q.cfg[g].mode == 2'h2);
			assign wake_active[g] = s_q.cfg[g].wake_en && (s_q.cfg[g].mode == 2'h3);
			assign basic_sample_clock[g] = basic[g];
			assign rx_bit_valid[g] = s_q.ch[g].bit_valid;
			assign rx_bit_value[g] = s_q.ch[g].rx_bit;
		end
	endgenerate

	// Next state: registers, prescaler, synchronisers, receive counters
	always_comb begin
		logic [3:0] cnt_n;
		logic maj;
		logic [3:0] total;
		s_d = s_q;
		cnt_n = 4'h0;
		maj = 1'b0;
		total = 4'h0;
		s_d.div4 = s_q.div4 + 2'h1;
		// Prescaler is held cleared while unused
		if (!presc_run) begin
			s_d.presc = 6'h00;
		end else if (tick4) begin
			s_d.presc = s_q.presc + 6'h01;
		end
		// Register writes take effect in the access cycle
		if (wr && hit) begin
			case (off)
				`SBCG_OFF_BAUD_CTRL: begin
					s_d.cfg[chs].int_divisor_n = pwdata[`SBCG_N_LSB +: 4];
					s_d.cfg[chs].baud_src_select = pwdata[`SBCG_SRC_LSB +: 2];
					s_d.cfg[chs].frac_div_enable = pwdata[`SBCG_FRAC_EN_BIT];
				end
				`SBCG_OFF_BAUD_FRAC: s_d.cfg[chs].frac_divisor_k = pwdata[`SBCG_K_LSB +: 4];
				`SBCG_OFF_SER_MODE: begin
					s_d.cfg[chs].sample_clock_src = pwdata[`SBCG_SCS_LSB +: 2];
					s_d.cfg[chs].mode = pwdata[`SBCG_MODE_LSB +: 2];
					s_d.cfg[chs].parity_en = pwdata[`SBCG_PAR_BIT];
					s_d.cfg[chs].wake_en = pwdata[`SBCG_WAKE_BIT];
				end
				`SBCG_OFF_SER_CTRL: begin
					s_d.cfg[chs].shift_clock_dir = pwdata[`SBCG_DIR_BIT];
					s_d.cfg[chs].shift_edge_select = pwdata[`SBCG_EDGE_BIT];
				end
				default: s_d.cfg[chs].spare = s_q.cfg[chs].spare;
			endcase
		end
		// Read data is sampled in setup and held through access
		if (setup) begin
			s_d.prdata = 32'h00000000;
			// Unmapped addresses must not alias onto a channel window
			case (hit ? off : 5'h1F)
				`SBCG_OFF_BAUD_CTRL: begin
					s_d.prdata[`SBCG_N_LSB +: 4] = s_q.cfg[chs].int_divisor_n;
					s_d.prdata[`SBCG_SRC_LSB +: 2] = s_q.cfg[chs].baud_src_select;
					s_d.prdata[`SBCG_FRAC_EN_BIT] = s_q.cfg[chs].frac_div_enable;
				end
				`SBCG_OFF_BAUD_FRAC: s_d.prdata[`SBCG_K_LSB +: 4] = s_q.cfg[chs].frac_divisor_k;
				`SBCG_OFF_SER_MODE: begin
					s_d.prdata[`SBCG_SCS_LSB +: 2] = s_q.cfg[chs].sample_clock_src;
					s_d.prdata[`SBCG_MODE_LSB +: 2] = s_q.cfg[chs].mode;
					s_d.prdata[`SBCG_PAR_BIT] = s_q.cfg[chs].parity_en;
					s_d.prdata[`SBCG_WAKE_BIT] = s_q.cfg[chs].wake_en;
				end
				`SBCG_OFF_SER_CTRL: begin
					s_d.prdata[`SBCG_DIR_BIT] = s_q.cfg[chs].shift_clock_dir;
					s_d.prdata[`SBCG_EDGE_BIT] = s_q.cfg[chs].shift_edge_select;
				end
				`SBCG_OFF_STATUS: begin
					s_d.prdata[3:0] = s_q.ch[chs].rx_cnt;
					s_d.prdata[5:4] = s_q.ch[chs].rx_st;
					s_d.prdata[6] = s_q.ch[chs].rx_bit;
					s_d.prdata[7] = s_q.ch[chs].sck_lvl;
					s_d.prdata[11:8] = s_q.ch[chs].bit_idx;
				end
				default: s_d.prdata = 32'h00000000;
			endcase
		end
		// Each channel runs on its own settings
		for (int i = 0; i < 2; i++) begin
			// Three flops; a change counts once the last two agree
			s_d.ch[i].rx_sync = {s_q.ch[i].rx_sync[1:0], ser_rx_pin[i]};
			s_d.ch[i].sck_sync = {s_q.ch[i].sck_sync[1:0], shift_clock_in[i]};
			if (s_q.ch[i].rx_sync[1] == s_q.ch[i].rx_sync[2]) begin
				s_d.ch[i].rx_lvl = s_q.ch[i].rx_sync[2];
			end
			if (s_q.ch[i].sck_sync[1] == s_q.ch[i].sck_sync[2]) begin
				s_d.ch[i].sck_lvl = s_q.ch[i].sck_sync[2];
			end
			s_d.ch[i].sck_prev = s_q.ch[i].sck_lvl;
			s_d.ch[i].bit_valid = 1'b0;
			// Output shift clock toggles on every baud pulse while I/O mode drives it out
			if (s_q.cfg[i].mode == 2'h0 && !s_q.cfg[i].shift_clock_dir && baud_pulse[i]) begin
				s_d.ch[i].half = !s_q.ch[i].half;
			end
			// Character length: data bits, optional parity, one stop
			case (s_q.cfg[i].mode)
				2'h1: total = `SBCG_BITS_M1;
				2'h2: total = `SBCG_BITS_M2;
				default: total = `SBCG_BITS_M3;
			endcase
			total = total + {3'h0, parity_active[i]};
			cnt_n = s_q.ch[i].rx_cnt + 4'h1;
			maj = (s_q.ch[i].votes[0] & s_q.ch[i].votes[1]) |
				(s_q.ch[i].votes[0] & s_q.ch[i].rx_lvl) |
				(s_q.ch[i].votes[1] & s_q.ch[i].rx_lvl);
			if (restart[i]) begin
				s_d.ch[i].rx_cnt = 4'h0;
				s_d.ch[i].rx_st = RX_IDLE;
				s_d.ch[i].half = 1'b0;
			end else if (s_q.cfg[i].mode == 2'h0) begin
				// Clocked I/O: one sample per basic clock edge
				s_d.ch[i].rx_st = RX_IDLE;
				if (basic[i]) begin
					s_d.ch[i].rx_bit = s_q.ch[i].rx_lvl;
					s_d.ch[i].bit_valid = 1'b1;
				end
			end else begin
				case (s_q.ch[i].rx_st)
					RX_IDLE: begin
						s_d.ch[i].rx_cnt = 4'h0;
						if (!s_q.ch[i].rx_lvl) begin
							s_d.ch[i].rx_st = RX_START;
						end
					end
					RX_START, RX_DATA: begin
						if (basic[i]) begin
							s_d.ch[i].rx_cnt = cnt_n;
							if (cnt_n == `SBCG_SAMPLE_A) begin
								s_d.ch[i].votes[0] = s_q.ch[i].rx_lvl;
							end
							if (cnt_n == `SBCG_SAMPLE_B) begin
								s_d.ch[i].votes[1] = s_q.ch[i].rx_lvl;
							end
							if (cnt_n == `SBCG_SAMPLE_C) begin
								// Third sample decides together with the first two
								if (s_q.ch[i].rx_st == RX_START) begin
									s_d.ch[i].rx_st = maj ? RX_IDLE : RX_DATA;
									s_d.ch[i].bit_idx = 4'h0;
								end else begin
									s_d.ch[i].rx_bit = maj;
									s_d.ch[i].bit_valid = 1'b1;
									s_d.ch[i].bit_idx = s_q.ch[i].bit_idx + 4'h1;
									if (s_q.ch[i].bit_idx == total) begin
										s_d.ch[i].rx_st = RX_IDLE;
									end
								end
							end
						end
					end
					default: s_d.ch[i].rx_st = RX_IDLE;
				endcase
			end
		end
	end

	// Single state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.prdata;

	property p_presc_hold;
		@(posedge pclk) disable iff (!presetn)
		!presc_run |=> s_q.presc == 6'h00;
	endproperty
	a_presc_hold: assert property (p_presc_hold) else $error("prescaler ran while unused");

	property p_tap_nest;
		@(posedge pclk) disable iff (!presetn)
		taps[3] |-> taps[2] && taps[1] && taps[0] && tick4;
	endproperty
	a_tap_nest: assert property (p_tap_nest) else $error("prescaler taps out of step");

	generate
		for (g = 0; g < 2; g++) begin : g_chk
			property p_cnt_step;
				@(posedge pclk) disable iff (!presetn)
				basic[g] && !restart[g] && s_q.cfg[g].mode != 2'h0 &&
				s_q.ch[g].rx_st != RX_IDLE |=> s_q.ch[g].rx_cnt == 4'($past(s_q.ch[g].rx_cnt) + 4'h1);
			endproperty
			a_cnt_step: assert property (p_cnt_step) else $error("receive counter missed a pulse");

			property p_sample_pt;
				@(posedge pclk) disable iff (!presetn)
				s_q.ch[g].bit_valid && s_q.cfg[g].mode != 2'h0 |-> s_q.ch[g].rx_cnt == `SBCG_SAMPLE_C;
			endproperty
			a_sample_pt: assert property (p_sample_pt) else $error("bit decided off count 9");

			property p_vote;
				@(posedge pclk) disable iff (!presetn)
				s_q.ch[g].rx_st == RX_DATA && basic[g] && !restart[g] &&
				s_q.cfg[g].mode != 2'h0 && s_q.ch[g].rx_cnt == `SBCG_SAMPLE_B
				|=> s_q.ch[g].rx_bit == ((s_q.ch[g].votes[0] & s_q.ch[g].votes[1]) |
				(s_q.ch[g].votes[0] & $past(s_q.ch[g].rx_lvl)) |
				(s_q.ch[g].votes[1] & $past(s_q.ch[g].rx_lvl)));
			endproperty
			a_vote: assert property (p_vote) else $error("bit is not the majority");

			property p_half;
				@(posedge pclk) disable iff (!presetn)
				baud_pulse[g] && !restart[g] && s_q.cfg[g].mode == 2'h0 &&
				!s_q.cfg[g].shift_clock_dir |=> shift_clock_out[g] != $past(shift_clock_out[g]);
			endproperty
			a_half: assert property (p_half) else $error("shift clock did not halve");

			property p_io_edge;
				@(posedge pclk) disable iff (!presetn)
				s_q.cfg[g].mode == 2'h0 && s_q.cfg[g].shift_clock_dir && basic[g]
				|-> s_q.ch[g].sck_lvl == !s_q.cfg[g].shift_edge_select;
			endproperty
			a_io_edge: assert property (p_io_edge) else $error("wrong shift clock edge");

			property p_restart;
				@(posedge pclk) disable iff (!presetn)
				restart[g] |=> s_q.ch[g].rx_cnt == 4'h0 && s_q.ch[g].rx_st == RX_IDLE;
			endproperty
			a_restart: assert property (p_restart) else $error("rewrite did not restart");

			property p_no_par9;
				@(posedge pclk) disable iff (!presetn)
				s_q.cfg[g].mode == 2'h3 |-> !parity_active[g] && !shift_clock_oe[g];
			endproperty
			a_no_par9: assert property (p_no_par9) else $error("parity in 9-bit mode");
		end
	endgenerate
endmodule : sbcg_top
